//--- verilog/tpms_defines.svh
/*
  Register offsets, field positions, reset values and timing counts for the
  transceiver power-mode sequencer. Assumes a 40 MHz system clock.
*/
`ifndef TPMS_DEFINES_SVH
`define TPMS_DEFINES_SVH

`define TPMS_CLK_MHZ          40
// Register byte offsets.
`define TPMS_OFF_MAIN         12'h000
`define TPMS_OFF_OSC_BIAS     12'h004
`define TPMS_OFF_FRONT_BIAS   12'h008
`define TPMS_OFF_BUFFER_BIAS  12'h00C
`define TPMS_OFF_CALIBRATE    12'h010
`define TPMS_OFF_STATUS       12'h014
`define TPMS_OFF_BANDWIDTH    12'h018
`define TPMS_OFF_IRQ_STATUS   12'h01C
`define TPMS_OFF_IRQ_ENABLE   12'h020
`define TPMS_OFF_IRQ_CLEAR    12'h024
// Main control bit positions.
`define TPMS_MAIN_RESET_N     0
`define TPMS_MAIN_RX_PD       1
`define TPMS_MAIN_TX_PD       2
`define TPMS_MAIN_SYNTH_PD    3
`define TPMS_MAIN_XOSC_PD     4
`define TPMS_MAIN_SEL_TX      5
`define TPMS_MAIN_RESET       8'h1F
// Bias register resets.
`define TPMS_OSC_BIAS_RESET   8'h44
`define TPMS_FRONT_RESET      8'h00
`define TPMS_BUFFER_RESET     8'h00
// Calibrate register fields.
`define TPMS_CAL_START        7
// Status bits.
`define TPMS_ST_CAL_DONE      7
`define TPMS_ST_LOCKED        4
`define TPMS_ST_CAL_RX        1
`define TPMS_ST_CAL_TX        0
// Interrupt bit positions.
`define TPMS_IRQ_CAL          0
`define TPMS_IRQ_LOCK         1
`define TPMS_IRQ_UNLOCK       2
// Settling times in microseconds, and the same in clock cycles.
`define TPMS_CAL_TIME_US      20000
`define TPMS_TURNON_NARROW_US 3200
`define TPMS_TURNON_WIDE_US   700
`define TPMS_RELOCK_NARROW_US 900
`define TPMS_RELOCK_WIDE_US   14
`define TPMS_RELOCK_1MHZ_US   1300
`define TPMS_TURNON_NARROW_CYC (`TPMS_TURNON_NARROW_US * `TPMS_CLK_MHZ)
`define TPMS_TURNON_WIDE_CYC   (`TPMS_TURNON_WIDE_US * `TPMS_CLK_MHZ)
`define TPMS_RELOCK_NARROW_CYC (`TPMS_RELOCK_NARROW_US * `TPMS_CLK_MHZ)
`define TPMS_RELOCK_WIDE_CYC   (`TPMS_RELOCK_WIDE_US * `TPMS_CLK_MHZ)
`define TPMS_RELOCK_1MHZ_CYC   (`TPMS_RELOCK_1MHZ_US * `TPMS_CLK_MHZ)
`define TPMS_CAL_CYC           (`TPMS_CAL_TIME_US * `TPMS_CLK_MHZ)

`endif

//--- verilog/tpms_pkg.sv
/*
  Types shared by the power-mode sequencer files.
  Assumes the defines header is compiled alongside.
*/
package tpms_pkg;
  typedef enum logic [2:0] {
    TPMS_OFF,
    TPMS_CAL,
    TPMS_SETTLE,
    TPMS_LOCKED,
    TPMS_IDLE
  } tpms_synth_t;
endpackage

//--- verilog/tpms_tmr_if.sv
/*
  Carrier between the sequencer and its settle timer.
  Assumes a single clock domain.
*/
`timescale 1ns/1ps
interface tpms_tmr_if;
  logic        start;
  logic [23:0] load;
  logic        done;
  modport ctrl (output start, output load, input done);
  modport tmr  (input start, input load, output done);
endinterface

//--- verilog/tpms_timer.sv
/*
  Down-counter giving a one-cycle done pulse after a loaded cycle count.
  Assumes synchronous active-high reset.
*/
`timescale 1ns/1ps
module tpms_timer (
  input  wire logic clk_in,
  input  wire logic sys_rst_in,
  tpms_tmr_if.tmr   tmr
);
  logic [23:0] count;
  logic        running;

  always_ff @(posedge clk_in) begin
    if (sys_rst_in) begin
      count   <= 24'h000000;
      running <= 1'b0;
    end else if (tmr.start) begin
      count   <= tmr.load;
      running <= 1'b1;
    end else if (running) begin
      count <= count - 24'h000001;
      if (count <= 24'h000001) begin
        running <= 1'b0;
      end
    end
  end

  assign tmr.done = running && (count <= 24'h000001) && !tmr.start;
endmodule

//--- verilog/tpms_irq.sv
/*
  Sticky event flags with enable mask and one level interrupt.
  Assumes events are one-cycle pulses; set wins over clear.
*/
`timescale 1ns/1ps
module tpms_irq (
  input  wire logic       clk_in,
  input  wire logic       sys_rst_in,
  input  wire logic [2:0] event_in,
  input  wire logic [2:0] clear_in,
  input  wire logic [2:0] enable_in,
  output logic      [2:0] status_out,
  output logic            irq_out
);
  always_ff @(posedge clk_in) begin
    if (sys_rst_in) begin
      status_out <= 3'h0;
    end else begin
      status_out <= (status_out & ~clear_in) | event_in;
    end
  end

  assign irq_out = |(status_out & enable_in);
endmodule

//--- verilog/tpms_sequencer.sv
/*
  Power-mode sequencer of a UHF transceiver: main control, bias settings,
  calibration and lock model, reached over APB with a level interrupt.
  Assumes one 40 MHz clock, synchronous reset, and an APB master.
*/
// The register addresses and register access over APB were chosen for this implementation.
`timescale 1ns/1ps
`include "tpms_defines.svh"

// Functional notes
// [RQ1] Turn-on from power down settles per bandwidth
// [RQ2] Receive/transmit switch relocks per bandwidth
// [RQ3] Settle times valid only after calibration
// [RQ4] Separate oscillator bias per frequency word; the code keeps one oscillator_bias_setting for both words
// [RQ5] Front and buffer bias registers programmable
// [RQ6] Individual power bits for four sections
// [RQ7] Host floats or raises select during powerdown
// [RQ8] Host soft-resets via active-low reset bit
// [RQ9] Configuration writes accepted in any order
// [RQ10] Host calibrates in receive and transmit
// [RQ11] Host follows recommended power-up order
// [RQ12] After calibration host runs mode setup
// [RQ13] Wake-up step then setup leaving powerdown
// [RQ14] Direct receive/transmit switch needs setup only
// [RQ15] Start bit begins calibration; done bit reports
// [RQ16] Lock flag in status and on pin
// [RQ17] Host waits for lock or settle time
module tpms_sequencer #(
  parameter logic [23:0] CAL_CYCLES = 24'(`TPMS_CAL_CYC)
) (
  input  wire logic        clk_in,
  input  wire logic        sys_rst_in,
  input  wire logic        psel_in,
  input  wire logic        penable_in,
  input  wire logic        pwrite_in,
  input  wire logic [11:0] paddr_in,
  input  wire logic [31:0] pwdata_in,
  output logic      [31:0] prdata_out,
  output logic             pready_out,
  output logic             pslverr_out,
  output logic             rx_power_out,
  output logic             tx_power_out,
  output logic             synth_power_out,
  output logic             xosc_power_out,
  output logic             lock_pin_out,
  output logic             irq_out
);
  // ==========================================================
  // Bus decode
  // ==========================================================
  wire wr_acc = psel_in && penable_in && pwrite_in;
  wire rd_acc = psel_in && penable_in && !pwrite_in;
  wire hit_main   = (paddr_in == `TPMS_OFF_MAIN);
  wire hit_osc    = (paddr_in == `TPMS_OFF_OSC_BIAS);
  wire hit_front  = (paddr_in == `TPMS_OFF_FRONT_BIAS);
  wire hit_buffer = (paddr_in == `TPMS_OFF_BUFFER_BIAS);
  wire hit_cal    = (paddr_in == `TPMS_OFF_CALIBRATE);
  wire hit_status = (paddr_in == `TPMS_OFF_STATUS);
  wire hit_bw     = (paddr_in == `TPMS_OFF_BANDWIDTH);
  wire hit_ist    = (paddr_in == `TPMS_OFF_IRQ_STATUS);
  wire hit_ien    = (paddr_in == `TPMS_OFF_IRQ_ENABLE);
  wire hit_icl    = (paddr_in == `TPMS_OFF_IRQ_CLEAR);
  wire mapped = hit_main | hit_osc | hit_front | hit_buffer | hit_cal | hit_status
              | hit_bw | hit_ist | hit_ien | hit_icl;

  // ==========================================================
  // Configuration registers
  // ==========================================================
  logic [7:0] main_ctrl;
  logic [7:0] oscillator_bias_setting;
  logic [7:0] front_bias_register;
  logic [7:0] buffer_bias_register;
  logic [1:0] bandwidth_sel;
  logic [2:0] irq_enable;
  logic [2:0] irq_status;
  wire        soft_rst = !main_ctrl[`TPMS_MAIN_RESET_N];
  wire        wr_main  = wr_acc && hit_main;
  wire        cal_go   = wr_acc && hit_cal && pwdata_in[`TPMS_CAL_START];

  // Soft reset returns every configuration register but main to default.
  always_ff @(posedge clk_in) begin
    if (sys_rst_in) begin
      main_ctrl <= `TPMS_MAIN_RESET;
    end else if (wr_main) begin
      main_ctrl <= pwdata_in[7:0]; // RQ6
    end
  end

  always_ff @(posedge clk_in) begin
    if (sys_rst_in || soft_rst) begin
      oscillator_bias_setting <= `TPMS_OSC_BIAS_RESET;
      front_bias_register     <= `TPMS_FRONT_RESET;
      buffer_bias_register    <= `TPMS_BUFFER_RESET;
      bandwidth_sel           <= 2'h0;
      irq_enable              <= 3'h0;
    end else if (wr_acc) begin
      // Any order of writes is accepted; each register stands alone.
      if (hit_osc) oscillator_bias_setting <= pwdata_in[7:0]; // RQ4 RQ9
      if (hit_front) front_bias_register <= pwdata_in[7:0]; // RQ5
      if (hit_buffer) buffer_bias_register <= pwdata_in[7:0]; // RQ5
      if (hit_bw) bandwidth_sel <= pwdata_in[1:0];
      if (hit_ien) irq_enable <= pwdata_in[2:0];
    end
  end

  assign rx_power_out    = !main_ctrl[`TPMS_MAIN_RX_PD]; // RQ6
  assign tx_power_out    = !main_ctrl[`TPMS_MAIN_TX_PD]; // RQ6
  assign synth_power_out = !main_ctrl[`TPMS_MAIN_SYNTH_PD]; // RQ6
  assign xosc_power_out  = !main_ctrl[`TPMS_MAIN_XOSC_PD]; // RQ6
  wire   sel_tx          = main_ctrl[`TPMS_MAIN_SEL_TX];

  // ==========================================================
  // Synthesizer model
  // ==========================================================
  tpms_tmr_if tif ();
  tpms_timer u_timer (
    .clk_in     (clk_in),
    .sys_rst_in (sys_rst_in),
    .tmr        (tif.tmr)
  );

  tpms_pkg::tpms_synth_t state;
  tpms_pkg::tpms_synth_t next_state;
  logic       cal_rx;
  logic       cal_tx;
  logic       cal_done;
  logic       cal_for_tx;
  logic       prev_tx;
  wire        synth_on  = synth_power_out && xosc_power_out;
  wire        switched  = synth_on && (sel_tx != prev_tx);
  wire        word_cal  = sel_tx ? cal_tx : cal_rx;

  // Settle counts per bandwidth: 0 narrowest, 3 widest.
  logic [23:0] turnon_cyc;
  logic [23:0] relock_cyc;
  always_comb begin
    case (bandwidth_sel)
      2'h0: begin
        turnon_cyc = 24'(`TPMS_TURNON_NARROW_CYC); // RQ1
        relock_cyc = 24'(`TPMS_RELOCK_NARROW_CYC); // RQ2
      end
      2'h1: begin
        turnon_cyc = 24'(`TPMS_TURNON_NARROW_CYC);
        relock_cyc = 24'(`TPMS_RELOCK_1MHZ_CYC); // RQ2
      end
      2'h2: begin
        turnon_cyc = 24'(`TPMS_TURNON_WIDE_CYC);
        relock_cyc = 24'(`TPMS_RELOCK_WIDE_CYC);
      end
      default: begin
        turnon_cyc = 24'(`TPMS_TURNON_WIDE_CYC); // RQ1
        relock_cyc = 24'(`TPMS_RELOCK_WIDE_CYC); // RQ2
      end
    endcase
  end

  logic        next_start;
  logic [23:0] next_load;
  always_comb begin
    next_state = state;
    next_start = 1'b0;
    next_load  = turnon_cyc;
    case (state)
      tpms_pkg::TPMS_OFF: begin
        if (synth_on && cal_go) begin
          next_state = tpms_pkg::TPMS_CAL; // RQ15
          next_start = 1'b1;
          next_load  = CAL_CYCLES;
        end else if (synth_on && word_cal) begin
          next_state = tpms_pkg::TPMS_SETTLE; // RQ1
          next_start = 1'b1;
        end else if (synth_on) begin
          next_state = tpms_pkg::TPMS_IDLE;
        end
      end
      tpms_pkg::TPMS_CAL: begin
        if (!synth_on) begin
          next_state = tpms_pkg::TPMS_OFF;
        end else if (tif.done) begin
          next_state = tpms_pkg::TPMS_LOCKED;
        end
      end
      tpms_pkg::TPMS_SETTLE, tpms_pkg::TPMS_LOCKED, tpms_pkg::TPMS_IDLE: begin
        if (!synth_on) begin
          next_state = tpms_pkg::TPMS_OFF;
        end else if (cal_go) begin
          next_state = tpms_pkg::TPMS_CAL;
          next_start = 1'b1;
          next_load  = CAL_CYCLES;
        end else if (switched) begin
          // Uncalibrated words never lock, so no settle time applies.
          next_state = word_cal ? tpms_pkg::TPMS_SETTLE : tpms_pkg::TPMS_IDLE; // RQ3
          next_start = word_cal;
          next_load  = relock_cyc; // RQ2
        end else if (state == tpms_pkg::TPMS_SETTLE && tif.done) begin
          next_state = tpms_pkg::TPMS_LOCKED; // RQ3
        end
      end
      default: next_state = tpms_pkg::TPMS_OFF;
    endcase
  end

  assign tif.start = next_start;
  assign tif.load  = next_load;

  wire cal_finish = (state == tpms_pkg::TPMS_CAL) && tif.done;
  wire locked     = (state == tpms_pkg::TPMS_LOCKED);

  always_ff @(posedge clk_in) begin
    if (sys_rst_in || soft_rst) begin
      state      <= tpms_pkg::TPMS_OFF;
      cal_rx     <= 1'b0;
      cal_tx     <= 1'b0;
      cal_done   <= 1'b0;
      cal_for_tx <= 1'b0;
      prev_tx    <= 1'b0;
    end else begin
      state   <= next_state;
      prev_tx <= sel_tx;
      if (next_start && next_load == CAL_CYCLES && cal_go) begin
        cal_done   <= 1'b0;
        cal_for_tx <= sel_tx;
      end else if (cal_finish) begin
        cal_done <= 1'b1; // RQ15
        if (cal_for_tx) begin
          cal_tx <= 1'b1; // RQ4
        end else begin
          cal_rx <= 1'b1;
        end
      end
    end
  end

  // ==========================================================
  // Lock pin and interrupts
  // ==========================================================
  logic locked_q;
  always_ff @(posedge clk_in) begin
    if (sys_rst_in) begin
      locked_q <= 1'b0;
    end else begin
      locked_q <= locked;
    end
  end
  assign lock_pin_out = locked; // RQ16

  wire [2:0] irq_events = {locked_q && !locked, locked && !locked_q, cal_finish};
  wire [2:0] irq_clear  = (wr_acc && hit_icl) ? pwdata_in[2:0] : 3'h0;
  tpms_irq u_irq (
    .clk_in     (clk_in),
    .sys_rst_in (sys_rst_in),
    .event_in   (irq_events),
    .clear_in   (irq_clear),
    .enable_in  (irq_enable),
    .status_out (irq_status),
    .irq_out    (irq_out)
  );

  // ==========================================================
  // Read path
  // ==========================================================
  wire [7:0] status_word = {cal_done, 2'h0, locked, 2'h0, cal_rx, cal_tx}; // RQ16
  wire [31:0] rd_mux =
      hit_main   ? {24'h000000, main_ctrl} :
      hit_osc    ? {24'h000000, oscillator_bias_setting} :
      hit_front  ? {24'h000000, front_bias_register} :
      hit_buffer ? {24'h000000, buffer_bias_register} :
      hit_status ? {24'h000000, status_word} :
      hit_bw     ? {30'h0, bandwidth_sel} :
      hit_ist    ? {29'h0, irq_status} :
      hit_ien    ? {29'h0, irq_enable} :
      32'h00000000;

  always_ff @(posedge clk_in) begin
    if (sys_rst_in) begin
      prdata_out <= 32'h00000000;
    end else if (psel_in && !penable_in && !pwrite_in) begin
      prdata_out <= rd_mux;
    end
  end

  // Read data is latched in setup, so the access phase completes at once.
  assign pready_out  = 1'b1;
  assign pslverr_out = psel_in && penable_in && !mapped;
endmodule

//--- tb/tpms_sequencer_asserts.sv
/*
  Checker bound to the sequencer top: APB answers, power pins, lock timing, interrupt mask.
  Assumes one clock and a synchronous active-high reset.
*/
`timescale 1ns/1ps
module tpms_sequencer_asserts #(
  parameter logic [23:0] CAL_CYCLES = 24'h32
) (
  input wire logic        clk_in,
  input wire logic        sys_rst_in,
  input wire logic        psel_in,
  input wire logic        penable_in,
  input wire logic        pwrite_in,
  input wire logic [11:0] paddr_in,
  input wire logic [31:0] pwdata_in,
  input wire logic [31:0] prdata_out,
  input wire logic        pready_out,
  input wire logic        pslverr_out,
  input wire logic        rx_power_out,
  input wire logic        tx_power_out,
  input wire logic        synth_power_out,
  input wire logic        xosc_power_out,
  input wire logic        lock_pin_out,
  input wire logic        irq_out
);
  // ==========
  // Helpers
  default clocking cb @(posedge clk_in);
  endclocking
  default disable iff (sys_rst_in);
  wire         acc     = psel_in && penable_in;
  wire         wr      = acc && pwrite_in;
  wire         main_wr = wr && paddr_in == 12'h000;
  wire         cal_wr  = wr && paddr_in == 12'h010 && pwdata_in[7];
  wire  [3:0]  pwr     = {xosc_power_out, synth_power_out, tx_power_out, rx_power_out};
  logic [23:0] cal_cnt;
  logic [16:0] on_cnt;
  logic [2:0]  irq_en;
  // Both counts restart on a main write, so each lock edge is timed from its cause.
  always_ff @(posedge clk_in) begin
    if (sys_rst_in || main_wr) begin
      cal_cnt <= 24'h0;
      on_cnt  <= 17'h0;
    end else begin
      cal_cnt <= cal_wr ? 24'h1 : cal_cnt + {23'h0, cal_cnt != 24'h0 && !lock_pin_out};
      on_cnt  <= on_cnt + {16'h0, ~&on_cnt};
    end
  end
  always_ff @(posedge clk_in) begin
    if (sys_rst_in) begin
      irq_en <= 3'h0;
    end else if (main_wr && !pwdata_in[0]) begin
      // Soft reset returns the enable mask to its default as well.
      irq_en <= 3'h0;
    end else if (wr && paddr_in == 12'h020) begin
      irq_en <= pwdata_in[2:0];
    end
  end
  // ==========
  // Properties
  AST_PREADY: assert property (acc |-> pready_out)
    else $error("access not answered at once");
  AST_SLVERR: assert property (acc && paddr_in[1:0] == 2'h0 |->
    pslverr_out == (paddr_in > 12'h024)) else $error("error flag wrong for address");
  AST_RD_UPPER: assert property (acc && !pwrite_in |-> prdata_out[31:8] == 24'h0 &&
    (!pslverr_out || prdata_out == 32'h0)) else $error("read data out of field");
  AST_PWR_SET: assert property (main_wr |=>
    {27'h0, pwr, 1'h0} == (~$past(pwdata_in) & 32'h1E)) else $error("power pins differ");
  AST_PWR_HOLD: assert property (!main_wr |=> $stable(pwr))
    else $error("power pins moved without a write");
  AST_LOCK_OFF: assert property ((!synth_power_out || !xosc_power_out) [*2] |->
    !lock_pin_out) else $error("lock shown while synthesizer is off");
  AST_CAL_TIME: assert property ($rose(lock_pin_out) && cal_cnt != 24'h0 |->
    cal_cnt >= CAL_CYCLES - 24'h2 && cal_cnt <= CAL_CYCLES + 24'h3)
    else $error("calibration length wrong");
  AST_TURNON_MIN: assert property ($rose(lock_pin_out) && cal_cnt == 24'h0 |->
    on_cnt >= 17'd558) else $error("lock came too early");
  AST_IRQ_MASK: assert property ((irq_en == 3'h0) [*2] |-> !irq_out)
    else $error("interrupt while all masked");
  cover property ($rose(lock_pin_out) && cal_cnt != 24'h0);
  cover property ($rose(lock_pin_out) && cal_cnt == 24'h0);
  cover property ($fell(irq_out));
  cover property (acc && pslverr_out);
endmodule

bind tpms_sequencer tpms_sequencer_asserts #(.CAL_CYCLES(CAL_CYCLES)) i_asserts (
  .clk_in(clk_in), .sys_rst_in(sys_rst_in), .psel_in(psel_in),
  .penable_in(penable_in), .pwrite_in(pwrite_in), .paddr_in(paddr_in),
  .pwdata_in(pwdata_in), .prdata_out(prdata_out), .pready_out(pready_out),
  .pslverr_out(pslverr_out), .rx_power_out(rx_power_out), .tx_power_out(tx_power_out),
  .synth_power_out(synth_power_out), .xosc_power_out(xosc_power_out),
  .lock_pin_out(lock_pin_out), .irq_out(irq_out));

//--- tb/tpms_host_model.sv
/*
  Host controller model: an APB master offering one transfer task.
  Assumes one clock; a transfer waits for the answer without a cycle limit.
*/
`timescale 1ns/1ps
module tpms_host_model (
  input  wire logic        clk_in,
  input  wire logic [31:0] prdata_in,
  input  wire logic        pready_in,
  input  wire logic        pslverr_in,
  output logic             psel_out,
  output logic             penable_out,
  output logic             pwrite_out,
  output logic      [11:0] paddr_out,
  output logic      [31:0] pwdata_out
);
  // ==========
  // Idle bus
  initial begin
    psel_out    = 1'h0;
    penable_out = 1'h0;
    pwrite_out  = 1'h0;
    paddr_out   = 12'h0;
    pwdata_out  = 32'h0;
  end
  // ==========
  // Transfer
  task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d,
                      output logic [31:0] rd, output logic err);
    @(posedge clk_in);
    psel_out   <= 1'h1;
    pwrite_out <= w;
    paddr_out  <= a;
    pwdata_out <= d;
    @(posedge clk_in);
    penable_out <= 1'h1;
    @(posedge clk_in);
    while (pready_in !== 1'h1) @(posedge clk_in);
    rd = prdata_in;
    err = pslverr_in;
    // Released lines show the inverse, so a stale value never passes for a held one.
    psel_out    <= 1'h0;
    penable_out <= 1'h0;
    paddr_out   <= ~a;
    pwdata_out  <= ~d;
  endtask
endmodule

//--- tb/tpms_sequencer_tb.sv
/*
  Testbench of the power-mode sequencer: register table, calibration, lock timing, interrupt.
  Assumes the host model drives APB and the checker is bound to the top.
*/
`timescale 1ns/1ps
module tpms_sequencer_tb;
  typedef struct {
    logic        wr;
    logic [11:0] a;
    logic [31:0] d;
    logic        err;
  } tpms_row_t;
  logic        clk_in     = 1'h0;
  logic        sys_rst_in = 1'h1;
  logic        psel, penable, pwrite, pready, pslverr, lock, irq, err;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [3:0]  pwr;
  int          num_errors = 0;
  int          n_tests    = 0;
  int          cyc        = 0;
  tpms_row_t   rows [16];

  always #12.5 clk_in = ~clk_in;

  tpms_host_model i_host (.clk_in(clk_in), .prdata_in(prdata), .pready_in(pready),
    .pslverr_in(pslverr), .psel_out(psel), .penable_out(penable), .pwrite_out(pwrite),
    .paddr_out(paddr), .pwdata_out(pwdata));
  tpms_sequencer #(.CAL_CYCLES(24'h32)) i_dut (.clk_in(clk_in), .sys_rst_in(sys_rst_in),
    .psel_in(psel), .penable_in(penable), .pwrite_in(pwrite), .paddr_in(paddr),
    .pwdata_in(pwdata), .prdata_out(prdata), .pready_out(pready), .pslverr_out(pslverr),
    .rx_power_out(pwr[0]), .tx_power_out(pwr[1]), .synth_power_out(pwr[2]),
    .xosc_power_out(pwr[3]), .lock_pin_out(lock), .irq_out(irq));

  // ==========
  // Tasks
  task automatic summarize();
    if (num_errors == 0 && n_tests > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask
  task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
    n_tests++;
    if (got !== exp) begin
      num_errors++;
      $display("CHECK FAILED %s expected %h got %h", name, exp, got);
    end
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    i_host.xfer(1'h1, a, d, rd, err);
  endtask
  task automatic rdc(input logic [11:0] a, input logic [31:0] exp);
    i_host.xfer(1'h0, a, 32'h0, rd, err);
    chk("read data", exp, rd);
  endtask
  // Pins are sampled two edges on, once lock and interrupt have followed a write.
  task automatic pins(input logic [5:0] exp);
    repeat (2) @(posedge clk_in);
    @(negedge clk_in);
    chk("irq lock power pins", {26'h0, exp}, {26'h0, irq, lock, pwr});
  endtask
  task automatic wait_lock(input int lo, input int hi);
    int n;
    n = 0;
    while (lock !== 1'h1 && n <= hi) begin
      @(posedge clk_in);
      n++;
    end
    chk("cycles to lock in window", 32'h1, {31'h0, n >= lo && n <= hi});
  endtask

  // The run needs about 29500 cycles; the ceiling leaves room without hiding a hang.
  always @(posedge clk_in) begin
    cyc <= cyc + 1;
    if (cyc == 40000) begin
      num_errors++;
      summarize();
    end
  end

  // ==========
  // Sequence
  initial begin
    rows = '{'{1'h0, 12'h000, 32'h1F, 1'h0},
             '{1'h0, 12'h004, 32'h44, 1'h0},
             '{1'h0, 12'h008, 32'h00, 1'h0},
             '{1'h0, 12'h00C, 32'h00, 1'h0},
             '{1'h0, 12'h014, 32'h00, 1'h0},
             '{1'h0, 12'h01C, 32'h00, 1'h0},
             '{1'h1, 12'h00C, 32'h5A, 1'h0},
             '{1'h1, 12'h004, 32'hA5, 1'h0},
             '{1'h1, 12'h008, 32'h3C, 1'h0},
             '{1'h0, 12'h004, 32'hA5, 1'h0},
             '{1'h0, 12'h008, 32'h3C, 1'h0},
             '{1'h0, 12'h00C, 32'h5A, 1'h0},
             '{1'h1, 12'h014, 32'hFF, 1'h0},
             '{1'h0, 12'h014, 32'h00, 1'h0},
             '{1'h1, 12'h100, 32'hFF, 1'h1},
             '{1'h0, 12'h100, 32'h00, 1'h1}};
    repeat (2) @(posedge clk_in);
    sys_rst_in <= 1'h0;
    foreach (rows[i]) begin
      i_host.xfer(rows[i].wr, rows[i].a, rows[i].d, rd, err);
      if (!rows[i].wr) chk("row read data", rows[i].d, rd);
      chk("row error flag", {31'h0, rows[i].err}, {31'h0, err});
    end
    wr(12'h000, 32'h00);
    wr(12'h000, 32'h1F);
    rdc(12'h004, 32'h44);
    wr(12'h018, 32'h02);
    wr(12'h020, 32'h01);
    wr(12'h000, 32'h05);
    pins(6'h0D);
    wr(12'h010, 32'h80);
    wait_lock(40, 70);
    rdc(12'h014, 32'h92);
    pins(6'h3D);
    wr(12'h024, 32'h07);
    pins(6'h1D);
    wr(12'h000, 32'h23);
    repeat (700) @(posedge clk_in);
    pins(6'h0E);
    wr(12'h010, 32'h80);
    wait_lock(40, 70);
    rdc(12'h014, 32'h93);
    wr(12'h024, 32'h07);
    wr(12'h000, 32'h05);
    repeat (3) @(posedge clk_in);
    wait_lock(545, 565);
    pins(6'h1D);
    wr(12'h000, 32'h0F);
    pins(6'h08);
    wr(12'h000, 32'h05);
    wait_lock(27950, 28050);
    sys_rst_in <= 1'h1;
    @(posedge clk_in);
    sys_rst_in <= 1'h0;
    rdc(12'h000, 32'h1F);
    rdc(12'h014, 32'h00);
    pins(6'h00);
    summarize();
  end
endmodule
